/* File: design/balise_frame_pkg.sv */
// constants, carrier struct and helpers shared by the telegram framer
package balise_frame_pkg;

  localparam int CLK_MHZ       = 250;
  localparam int BIT_RATE_KBPS = 2500;
  // half a line bit in clock cycles, 400 ns bit at 4 ns clock
  localparam int HALF_CYCLES   = (CLK_MHZ * 1000) / (2 * BIT_RATE_KBPS);
  localparam int FRAME_US      = 20;
  localparam int TAIL_MIN_US   = 10;
  localparam int LEAD_BITS     = 1;
  localparam int INFO_BITS     = 16;
  localparam int CHECK_BITS    = 8;
  localparam int TAIL_NOM      = 25;
  // nominal bits per frame, must equal FRAME_US at the line rate
  localparam int FRAME_BITS    = LEAD_BITS + INFO_BITS + CHECK_BITS + TAIL_NOM;
  localparam int FRAME_CYCLES  = FRAME_BITS * 2 * HALF_CYCLES;

  localparam int TIMER_W = 6;
  localparam int INDEX_W = 5;
  localparam int CRC_W   = 8;

  localparam logic [TIMER_W-1:0] HALF_LAST  = TIMER_W'(HALF_CYCLES - 1);
  localparam logic [INDEX_W-1:0] INFO_LAST  = INDEX_W'(INFO_BITS - 1);
  localparam logic [INDEX_W-1:0] CHECK_LAST = INDEX_W'(CHECK_BITS - 1);
  localparam logic [INDEX_W-1:0] TAIL_LEN   = INDEX_W'(TAIL_NOM);
  localparam logic [INDEX_W-1:0] CRC_STEPS  = INDEX_W'(INFO_BITS + CHECK_BITS);
  localparam logic [INDEX_W-1:0] INFO_STEPS = INDEX_W'(INFO_BITS);

  // x8 term implied; x7 x4 x3 x1 x0
  localparam logic [CRC_W-1:0] CRC_POLY = 8'h9b;
  localparam logic [CRC_W-1:0] CRC_INIT = 8'h00;
  localparam logic [2:0]       SEQ_INIT = 3'h0;
  localparam logic [3:0]       STRENGTH_NONE = 4'h0;

  // bit 0 goes on the line first
  typedef struct packed {
    logic [3:0] strength;
    logic       link_test;
    logic       foreign_rx;
    logic       unavailable;
    logic       optimal;
    logic       fixed;
    logic [2:0] seq;
    logic [1:0] channel;
    logic [1:0] antenna;
  } info_s;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_LEAD  = 5'h02,
    ST_INFO  = 5'h04,
    ST_CHECK = 5'h08,
    ST_TAIL  = 5'h10
  } frame_state_e;

  // class 1 is a falling mid-cell edge; a one keeps the class, a zero flips it
  function automatic logic next_class(input logic prev_class, input logic bit_value);
    next_class = bit_value ? prev_class : ~prev_class;
  endfunction

endpackage

/* File: design/balise_crc8.sv */
// serial check value register, cleared then shifted one bit per cycle
module balise_crc8 (
  input  wire logic                                 clk,
  input  wire logic                                 rst_n,
  input  wire logic                                 clear,
  input  wire logic                                 shift,
  input  wire logic                                 din,
  output logic [balise_frame_pkg::CRC_W-1:0]        crc_q
);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crc_q <= balise_frame_pkg::CRC_INIT;
    end else if (clear) begin
      crc_q <= balise_frame_pkg::CRC_INIT;
    end else if (shift) begin
      // bits enter at the low end so the register top is the msb
      crc_q <= {crc_q[6:0], din} ^ (crc_q[7] ? balise_frame_pkg::CRC_POLY : 8'h00);
    end
  end

endmodule

/* File: design/balise_link_frame_codec.sv */
// telegram framer: builds, protects and bi-phase codes one frame per 20 us

// Operation
// - two antenna id bits, first bit is the low bit of the antenna number
// - two channel id bits coded like the antenna id
// - three-bit wrapping counter, one step per sent sample, first bit lsb
// - one low lead bit opens every frame; frames repeat every 20 us
// - check value uses polynomial 1+x+x3+x4+x7+x8 over information bits only
// - check register cleared to zero before every computation
// - check value msb is shifted and sent first
// - encode: shift 16 information bits then eight zeros, result is check value
// - nominal 25 high tail bits end each frame
// - one tail bit may be added or dropped per frame for drift
// - without a separate optimal bit, send the fixed-threshold bit twice
// - without a strength measurement, all four strength bits are zero
// - every line bit, lead and tail included, is bi-phase-level coded
// - only one of up to four transmitters enables its line driver
// - detection bits are zero with air-gap energy, one without
// - unavailable, foreign and link test flags are one when active
// - strength is 4-bit unsigned, first bit lsb, all ones strongest
module balise_link_frame_codec (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tx_enable,
  input  wire logic [1:0] antenna_id,
  input  wire logic [1:0] channel_id,
  input  wire logic       fixed_detect_bit,
  input  wire logic       optimal_detect_bit,
  input  wire logic       optimal_valid,
  input  wire logic       unavailable_flag,
  input  wire logic       foreign_rx_flag,
  input  wire logic       link_test_flag,
  input  wire logic [3:0] strength,
  input  wire logic       strength_valid,
  input  wire logic       tail_insert,
  input  wire logic       tail_drop,
  output logic            line_out,
  output logic            line_oe_n,
  output logic            frame_start,
  output logic [2:0]      seq_count,
  output logic            busy
);

  balise_frame_pkg::frame_state_e       state_q;
  balise_frame_pkg::info_s              info_q;
  balise_frame_pkg::info_s              info_d;
  logic [balise_frame_pkg::TIMER_W-1:0] timer_q;
  logic                                 half_q;
  logic [balise_frame_pkg::INDEX_W-1:0] index_q;
  logic [balise_frame_pkg::INDEX_W-1:0] tail_len_q;
  logic [balise_frame_pkg::INDEX_W-1:0] tail_len_d;
  logic [balise_frame_pkg::INDEX_W-1:0] crc_step_q;
  logic [balise_frame_pkg::CRC_W-1:0]   crc_value;
  logic [2:0]                           seq_q;
  logic                                 class_q;
  logic                                 class_cur;
  logic                                 bit_value;
  logic                                 bit_end;
  logic                                 tail_done;
  logic                                 launch;
  logic                                 crc_shift;
  logic                                 crc_din;

  // sample word captured at the frame boundary so it stays steady on the line
  always_comb begin
    info_d.antenna     = antenna_id;
    info_d.channel     = channel_id;
    info_d.seq         = seq_q;
    info_d.fixed       = fixed_detect_bit;
    info_d.optimal     = optimal_valid ? optimal_detect_bit : fixed_detect_bit;
    info_d.unavailable = unavailable_flag;
    info_d.foreign_rx  = foreign_rx_flag;
    info_d.link_test   = link_test_flag;
    info_d.strength    = strength_valid ? strength : balise_frame_pkg::STRENGTH_NONE;
  end

  // the request pair cancels out, keeping the nominal count
  always_comb begin
    tail_len_d = balise_frame_pkg::TAIL_LEN;
    if (tail_insert && !tail_drop) begin
      tail_len_d = balise_frame_pkg::TAIL_LEN + 5'h01;
    end else if (tail_drop && !tail_insert) begin
      tail_len_d = balise_frame_pkg::TAIL_LEN - 5'h01;
    end
  end

  assign bit_end   = half_q && (timer_q == balise_frame_pkg::HALF_LAST);
  assign tail_done = (state_q == balise_frame_pkg::ST_TAIL) && bit_end
                     && (index_q == tail_len_q - 5'h01);
  // back-to-back frames keep the 20 us cadence; idle waits for enable
  assign launch    = tx_enable && ((state_q == balise_frame_pkg::ST_IDLE) || tail_done);

  // frame sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= balise_frame_pkg::ST_IDLE;
      index_q <= 5'h00;
    end else if (launch) begin
      state_q <= balise_frame_pkg::ST_LEAD;
      index_q <= 5'h00;
    end else if (bit_end) begin
      case (state_q)
        balise_frame_pkg::ST_LEAD: begin
          state_q <= balise_frame_pkg::ST_INFO;
          index_q <= 5'h00;
        end
        balise_frame_pkg::ST_INFO: begin
          if (index_q == balise_frame_pkg::INFO_LAST) begin
            state_q <= balise_frame_pkg::ST_CHECK;
            index_q <= 5'h00;
          end else begin
            index_q <= index_q + 5'h01;
          end
        end
        balise_frame_pkg::ST_CHECK: begin
          if (index_q == balise_frame_pkg::CHECK_LAST) begin
            state_q <= balise_frame_pkg::ST_TAIL;
            index_q <= 5'h00;
          end else begin
            index_q <= index_q + 5'h01;
          end
        end
        balise_frame_pkg::ST_TAIL: begin
          if (tail_done) begin
            state_q <= balise_frame_pkg::ST_IDLE;
          end
          index_q <= index_q + 5'h01;
        end
        default: begin
          state_q <= balise_frame_pkg::ST_IDLE;
          index_q <= 5'h00;
        end
      endcase
    end
  end

  // half-bit timer; restarted by launch so a new frame starts on a clean cell
  always_ff @(posedge clk) begin
    if (!rst_n || launch || state_q == balise_frame_pkg::ST_IDLE) begin
      timer_q <= 6'h00;
      half_q  <= 1'b0;
    end else if (timer_q == balise_frame_pkg::HALF_LAST) begin
      timer_q <= 6'h00;
      half_q  <= ~half_q;
    end else begin
      timer_q <= timer_q + 6'h01;
    end
  end

  // frame capture and counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      info_q     <= '0;
      tail_len_q <= balise_frame_pkg::TAIL_LEN;
      seq_q      <= balise_frame_pkg::SEQ_INIT;
    end else if (launch) begin
      info_q     <= info_d;
      tail_len_q <= tail_len_d;
      seq_q      <= seq_q + 3'h1;
    end
  end

  // the check value is ready 24 cycles into the 100-cycle lead bit
  always_ff @(posedge clk) begin
    if (!rst_n || launch) begin
      crc_step_q <= 5'h00;
    end else if (crc_shift) begin
      crc_step_q <= crc_step_q + 5'h01;
    end
  end

  assign crc_shift = (state_q == balise_frame_pkg::ST_LEAD)
                     && (crc_step_q < balise_frame_pkg::CRC_STEPS);
  // information bits in line order, then eight zeros
  assign crc_din   = (crc_step_q < balise_frame_pkg::INFO_STEPS) ?
                     info_q[crc_step_q[3:0]] : 1'b0;

  balise_crc8 u_crc (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (launch),
    .shift (crc_shift),
    .din   (crc_din),
    .crc_q (crc_value)
  );

  always_comb begin
    case (state_q)
      balise_frame_pkg::ST_LEAD:  bit_value = 1'b0;
      balise_frame_pkg::ST_INFO:  bit_value = info_q[index_q[3:0]];
      balise_frame_pkg::ST_CHECK: bit_value = crc_value[3'h7 - index_q[2:0]];
      balise_frame_pkg::ST_TAIL:  bit_value = 1'b1;
      default:                    bit_value = 1'b1;
    endcase
  end

  assign class_cur = balise_frame_pkg::next_class(class_q, bit_value);

  // edge class carries across frames so the receiver's first comparison holds
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      class_q <= 1'b1;
    end else if (bit_end) begin
      class_q <= class_cur;
    end
  end

  // line stage lags the sequencer by one cycle for every bit alike
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_out  <= 1'b1;
      line_oe_n <= 1'b1;
    end else begin
      line_out  <= (state_q == balise_frame_pkg::ST_IDLE) ? 1'b1 :
                   (half_q ? ~class_cur : class_cur);
      // driver released while idle so another transmitter may take the line
      line_oe_n <= (state_q == balise_frame_pkg::ST_IDLE);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_start <= 1'b0;
      busy        <= 1'b0;
      seq_count   <= balise_frame_pkg::SEQ_INIT;
    end else begin
      frame_start <= launch;
      busy        <= launch || (state_q != balise_frame_pkg::ST_IDLE && !tail_done);
      seq_count   <= launch ? seq_q + 3'h1 : seq_q;
    end
  end

endmodule

/* File: tb/balise_link_frame_codec_asserts.sv */
// port-level checker for the telegram framer
module balise_frame_checker (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       tx_enable,
  input wire logic       tail_insert,
  input wire logic       tail_drop,
  input wire logic       line_out,
  input wire logic       line_oe_n,
  input wire logic       frame_start,
  input wire logic [2:0] seq_count,
  input wire logic       busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0]  ph_q;
  logic [15:0] len_q;
  logic [15:0] exp_q;
  logic        v_q;
  // 0 on the frame_start cycle; the line lags it by one cycle, so cells change at 1 and 51
  wire logic [6:0] ph = frame_start ? 7'h00 : ph_q;

  always_ff @(posedge clk) ph_q <= (ph == 7'h63) ? 7'h00 : ph + 7'h01;
  always_ff @(posedge clk) len_q <= frame_start ? 16'h0001 : len_q + 16'h0001;
  // tail request was sampled at the launch edge, one edge before frame_start shows
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      v_q <= 1'b0;
    end else if (frame_start) begin
      v_q   <= 1'b1;
      exp_q <= 16'h1388 + (($past(tail_insert) && !$past(tail_drop)) ? 16'h0064 : 16'h0000)
               - (($past(tail_drop) && !$past(tail_insert)) ? 16'h0064 : 16'h0000);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // sampled reset keeps the release edge out; the launch itself comes one edge later
  a_launch_when_idle: assert property
    (rst_n && !busy && tx_enable |=> frame_start)
    else $error("no frame launched while idle and enabled");
  a_no_launch_off: assert property (!busy && !tx_enable |=> !frame_start)
    else $error("frame launched while disabled");
  a_start_one_cycle: assert property (frame_start |=> !frame_start)
    else $error("frame_start longer than one cycle");
  a_frame_length: assert property
    (v_q && ((frame_start && $past(busy)) || $fell(busy)) |-> len_q == exp_q)
    else $error("frame length differs from lead, info, check and tail bits");
  // the driver stage lags busy by one cycle at both ends of a frame
  a_driver_busy: assert property (line_oe_n == !$past(busy))
    else $error("line driver enable does not follow frame activity");
  a_idle_high: assert property (line_oe_n |-> line_out)
    else $error("line not high while driver released");
  a_mid_cell_edge: assert property
    (busy && ph == 7'h33 |-> line_out != $past(line_out))
    else $error("missing mid-cell transition");
  a_half_stable: assert property
    (busy && ph != 7'h33 && ph != 7'h01 |-> $stable(line_out))
    else $error("line moved inside a half cell");
  a_seq_step: assert property (frame_start |-> seq_count == $past(seq_count) + 3'h1)
    else $error("sequence counter did not step by one");
  a_seq_hold: assert property (!frame_start |-> $stable(seq_count))
    else $error("sequence counter moved without a frame");
endmodule

bind balise_link_frame_codec balise_frame_checker chk (
  .clk         (clk),
  .rst_n       (rst_n),
  .tx_enable   (tx_enable),
  .tail_insert (tail_insert),
  .tail_drop   (tail_drop),
  .line_out    (line_out),
  .line_oe_n   (line_oe_n),
  .frame_start (frame_start),
  .seq_count   (seq_count),
  .busy        (busy)
);

/* File: tb/line_receiver.sv */
// receiver model: decodes bi-phase-level line, checks frame layout and check value
module line_receiver (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        line_out,
  input  wire logic        line_oe_n,
  input  wire logic        frame_start,
  output logic             rx_done,
  output logic [15:0]      rx_info,
  output logic [7:0]       rx_check,
  output logic [5:0]       rx_tail,
  output logic             rx_good
);
  timeunit 1ns;
  timeprecision 1ps;
  int         p_q;
  logic       act_q, cls_q, h1_q, bad_q;
  logic [15:0] inf_q;
  logic [7:0] chk_q, crc_q;
  logic [5:0] tail_q;

  always_ff @(posedge clk) begin
    int   p;
    int   k;
    logic b;
    rx_done <= 1'b0;
    p = frame_start ? 0 : p_q;
    p_q <= p + 1;
    if (!rst_n) begin
      act_q <= 1'b0;
      cls_q <= 1'b1;
    end else begin
      if (act_q && (frame_start || line_oe_n)) begin
        rx_done  <= 1'b1;
        rx_info  <= inf_q;
        rx_check <= chk_q;
        rx_tail  <= tail_q;
        rx_good  <= !bad_q && crc_q == 8'h00;
      end
      if (frame_start) begin
        act_q  <= 1'b1;
        bad_q  <= 1'b0;
        crc_q  <= 8'h00;
        tail_q <= 6'h00;
      end else if (line_oe_n) begin
        act_q <= 1'b0;
      end
      // sample mid-half so either edge polarity is tolerated
      if ((act_q || frame_start) && p % 100 == 25) h1_q <= line_out;
      if (act_q && p % 100 == 75) begin
        k = p / 100;
        b = (h1_q == cls_q);
        cls_q <= h1_q;
        if (line_out == h1_q || (k == 0 && b) || (k >= 25 && !b)) bad_q <= 1'b1;
        if (k >= 1 && k <= 16) inf_q[k-1] <= b;
        if (k >= 17 && k <= 24) chk_q[24-k] <= b;
        if (k >= 1 && k <= 24) crc_q <= {crc_q[6:0], b} ^ (crc_q[7] ? 8'h9b : 8'h00);
        if (k >= 25) tail_q <= tail_q + 6'h01;
      end
    end
  end
endmodule

/* File: tb/tb_balise_link_frame_codec.sv */
// self-checking bench for the telegram framer
module tb_balise_link_frame_codec;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, tx_enable = 1'b0;
  logic [1:0] antenna_id = 2'h0, channel_id = 2'h0;
  logic fixed_detect_bit = 1'b0, optimal_detect_bit = 1'b0, optimal_valid = 1'b0;
  logic unavailable_flag = 1'b0, foreign_rx_flag = 1'b0, link_test_flag = 1'b0;
  logic [3:0] strength = 4'h0;
  logic strength_valid = 1'b0, tail_insert = 1'b0, tail_drop = 1'b0;
  logic line_out, line_oe_n, frame_start, busy, rx_done, rx_good;
  logic [2:0] seq_count, frames_q;
  logic [15:0] rx_info;
  logic [7:0] rx_check;
  logic [5:0] rx_tail;
  int error_cnt = 0, n_tests = 0;

  always #2 clk = ~clk;
  always @(posedge clk) frames_q <= !rst_n ? 3'h0 : frames_q + 3'(frame_start);

  balise_link_frame_codec dut (
    .clk                (clk),
    .rst_n              (rst_n),
    .tx_enable          (tx_enable),
    .antenna_id         (antenna_id),
    .channel_id         (channel_id),
    .fixed_detect_bit   (fixed_detect_bit),
    .optimal_detect_bit (optimal_detect_bit),
    .optimal_valid      (optimal_valid),
    .unavailable_flag   (unavailable_flag),
    .foreign_rx_flag    (foreign_rx_flag),
    .link_test_flag     (link_test_flag),
    .strength           (strength),
    .strength_valid     (strength_valid),
    .tail_insert        (tail_insert),
    .tail_drop          (tail_drop),
    .line_out           (line_out),
    .line_oe_n          (line_oe_n),
    .frame_start        (frame_start),
    .seq_count          (seq_count),
    .busy               (busy)
  );
  line_receiver rx (
    .clk         (clk),
    .rst_n       (rst_n),
    .line_out    (line_out),
    .line_oe_n   (line_oe_n),
    .frame_start (frame_start),
    .rx_done     (rx_done),
    .rx_info     (rx_info),
    .rx_check    (rx_check),
    .rx_tail     (rx_tail),
    .rx_good     (rx_good)
  );

  function automatic logic [7:0] crc_ref(input logic [15:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 24; i++) r = {r[6:0], (i < 16) ? d[i] : 1'b0} ^ (r[7] ? 8'h9b : 8'h00);
    return r;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("compares %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // sel 0 waits for frame_start, 1 for a decoded frame; a timeout counts as a mismatch
  task automatic wait_for(input int sel, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(posedge clk);
      #1;
      if ((sel == 0 ? frame_start : rx_done) === 1'b1) break;
    end
    chk(16'(k < lim), 16'h0001);
  endtask

  task automatic t_reset;
    @(posedge clk);
    #1;
    chk({line_out, line_oe_n, busy, frame_start, seq_count}, 16'h0060);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (200) @(posedge clk);
    #1;
    chk({line_out, line_oe_n, busy, frame_start, seq_count}, 16'h0060);
    $display("t_reset done");
  endtask

  task automatic t_fields;
    balise_frame_pkg::info_s e;
    logic [2:0] c;
    logic ins, drp;
    for (int i = 0; i < 5; i++) begin
      c = 3'(i);
      ins = (i == 1 || i == 3);
      drp = (i == 2 || i == 3);
      @(posedge clk);
      {antenna_id, channel_id} <= {c[1:0], ~c[1:0]};
      {fixed_detect_bit, optimal_detect_bit, optimal_valid} <= {c[0], ~c[0], c[1]};
      {unavailable_flag, foreign_rx_flag, link_test_flag} <= {c[0], c[1], c[2]};
      strength <= 4'hf - 4'(c);
      strength_valid <= (i != 2);
      {tail_insert, tail_drop, tx_enable} <= {ins, drp, 1'b1};
      e = '{strength: (i != 2) ? 4'hf - 4'(c) : 4'h0, link_test: c[2], foreign_rx: c[1],
            unavailable: c[0], optimal: c[1] ? ~c[0] : c[0], fixed: c[0], seq: 3'h0,
            channel: ~c[1:0], antenna: c[1:0]};
      // every other frame is decoded, so the counter wraps past seven within the loop
      wait_for(0, 10100);
      // frames_q has not counted this pulse yet, so it equals this frame's counter
      e.seq = frames_q;
      // the edge after a back-to-back start carries the previous frame's decode
      @(posedge clk);
      wait_for(1, 5200);
      chk(rx_info, e);
      chk(16'(rx_check), 16'(crc_ref(e)));
      chk(16'(rx_good), 16'h0001);
      chk(16'(rx_tail), 16'd25 + 16'(ins && !drp) - 16'(drp && !ins));
    end
    $display("t_fields done");
  endtask

  task automatic t_stop;
    @(posedge clk);
    tx_enable <= 1'b0;
    wait_for(1, 5200);
    chk({busy, line_oe_n, line_out, rx_good}, 16'h0007);
    repeat (300) @(posedge clk);
    #1;
    chk({busy, line_oe_n}, 16'h0001);
    $display("t_stop done");
  endtask

  task automatic t_mid_reset;
    @(posedge clk);
    tx_enable <= 1'b1;
    wait_for(0, 10);
    repeat (1000) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({line_out, line_oe_n, busy, frame_start, seq_count}, 16'h0060);
    @(posedge clk);
    rst_n <= 1'b1;
    wait_for(0, 3);
    chk(16'(seq_count), 16'h0001);
    @(posedge clk);
    tx_enable <= 1'b0;
    wait_for(1, 5200);
    chk({rx_good, rx_info[6:4]}, 16'h0008);
    $display("t_mid_reset done");
  endtask

  initial begin
    t_reset();
    t_fields();
    t_stop();
    t_mid_reset();
    summarize();
  end

  initial begin
    #400000;
    error_cnt++;
    summarize();
  end
endmodule
